// ---- common/bisr_pkg.sv ----
// Constants for the bridge identity status register block
package bisr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  BISR_OFS_IDENT    = 8'h84;   // Byte offset of the register
  localparam logic [31:0] BISR_UNMAPPED_VAL = 32'h0000_0000; // Read value elsewhere

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BISR_FUNC_LSB = 0;    // Function number 2:0
  localparam int BISR_FUNC_MSB = 2;
  localparam int BISR_DEV_LSB  = 3;    // Device number 7:3
  localparam int BISR_DEV_MSB  = 7;
  localparam int BISR_BUS_LSB  = 8;    // Bus number 15:8
  localparam int BISR_BUS_MSB  = 15;
  localparam int BISR_B64_BIT  = 16;   // 64-bit primary capability bit

  // ****************************************
  // Reset and fixed values
  // ****************************************
  localparam logic [2:0] BISR_FUNC_RST = 3'h0;   // Function number after reset
  localparam logic [4:0] BISR_DEV_RST  = 5'h1F;  // Device number after reset
  localparam logic [7:0] BISR_BUS_RST  = 8'hFF;  // Bus number after reset
  localparam logic       BISR_B64_VAL  = 1'b0;   // No 64-bit primary interface

  // ****************************************
  // Address phase decode
  // ****************************************
  localparam logic [3:0] BISR_CMD_CFG_WR = 4'hB;  // Configuration write command
  localparam logic [1:0] BISR_TYPE0      = 2'h0;  // AD[1:0] of a type 0 access
  localparam int BISR_AD_FUNC_LSB = 8;            // AD[10:8] function select
  localparam int BISR_AD_FUNC_MSB = 10;
  localparam int BISR_AD_DEV_LSB  = 11;           // AD[15:11] device number
  localparam int BISR_AD_DEV_MSB  = 15;

endpackage

// ---- rtl/bisr_ident_status.sv ----
// Bridge identity status register: function, device and bus numbers
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Function number field, bits 2:0, resets 000
// - Device number field, bits 7:3, resets 11111
// - Config write hit loads device from AD[15:11]
// - Hit: cfg write, IDSEL, type 0, function match
// - Bus number mirrors primary bus, resets FF
// - Split completion ID built from bus/dev/func
// - Same ID used in conventional PCI mode
// - Bit 16 always reads zero
module bisr_ident_status
  import bisr_pkg::*;
(
  input  wire logic        clk,          // 40 MHz bus clock
  input  wire logic        arst_n,       // Asynchronous reset, active low
  input  wire logic        ap_valid,     // Address phase present this cycle
  input  wire logic [3:0]  ap_cmd,       // Bus command of the address phase
  input  wire logic        ap_idsel,     // IDSEL during the address phase
  input  wire logic [31:0] ap_ad,        // AD lines during the address phase
  input  wire logic [7:0]  pri_bus_num,  // Primary bus number register of the header
  input  wire logic        rd_req,       // Register read request
  input  wire logic [7:0]  rd_offset,    // Byte offset of the read
  output logic             rd_valid,     // Read data valid, one cycle
  output logic [31:0]      rd_data,      // Read data
  output logic [15:0]      cpl_id        // Completer ID {bus, dev, func}
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // True when an address phase is a type 0 config write aimed at this function
  function automatic logic cfg_wr_hit(input logic       v,
                                      input logic [3:0]  cmd,
                                      input logic        sel,
                                      input logic [31:0] ad,
                                      input logic [2:0]  fn);
    cfg_wr_hit = v && (cmd == BISR_CMD_CFG_WR) && sel
                 && (ad[1:0] == BISR_TYPE0)
                 && (ad[BISR_AD_FUNC_MSB:BISR_AD_FUNC_LSB] == fn);
  endfunction

  // Assemble the 32-bit register image from the fields
  function automatic logic [31:0] ident_word(input logic [7:0] bus,
                                             input logic [4:0] dev,
                                             input logic [2:0] fn);
    ident_word                              = 32'h0000_0000;
    ident_word[BISR_FUNC_MSB:BISR_FUNC_LSB] = fn;
    ident_word[BISR_DEV_MSB:BISR_DEV_LSB]   = dev;
    ident_word[BISR_BUS_MSB:BISR_BUS_LSB]   = bus;
    ident_word[BISR_B64_BIT]                = BISR_B64_VAL;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]  func;       // Function number
    logic [4:0]  dev;        // Device number
    logic [7:0]  bus;        // Mirrored bus number
    logic        rd_valid;   // Read answer strobe
    logic [31:0] rd_data;    // Read answer data
    logic [15:0] cpl_id;     // Completer ID as driven out
  } bisr_state_t;

  bisr_state_t st;       // Registered state
  bisr_state_t next_st;  // Next state

  logic hit;  // Config write addressed to this function

  // ****************************************
  // Next state logic
  // ****************************************

  // One pass fills every field; read-only fields have no write path at all
  always_comb begin
    next_st = st;
    hit     = cfg_wr_hit(ap_valid, ap_cmd, ap_idsel, ap_ad, st.func);
    // Single-function bridge: function number is never rewritten
    next_st.func = st.func;
    if (hit) begin
      // Any register may be the target; capture happens regardless
      next_st.dev = ap_ad[BISR_AD_DEV_MSB:BISR_AD_DEV_LSB];
    end
    // Bus number follows the header register; write data never reaches it
    next_st.bus = pri_bus_num;
    // Completer ID, also the identity used in conventional PCI mode
    next_st.cpl_id = {st.bus, st.dev, st.func};
    // Read answer; direct writes to 0x84 carry no data path here
    next_st.rd_valid = rd_req;
    if (rd_req && (rd_offset == BISR_OFS_IDENT)) begin
      next_st.rd_data = ident_word(st.bus, st.dev, st.func);
    end else if (rd_req) begin
      // Unmapped offsets answer with zero rather than stale data
      next_st.rd_data = BISR_UNMAPPED_VAL;
    end else begin
      next_st.rd_data = st.rd_data;
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Constants only under reset; the fields show their reset values at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.func     <= BISR_FUNC_RST;
      st.dev      <= BISR_DEV_RST;
      st.bus      <= BISR_BUS_RST;
      st.rd_valid <= 1'b0;
      st.rd_data  <= 32'h0000_0000;
      st.cpl_id   <= {BISR_BUS_RST, BISR_DEV_RST, BISR_FUNC_RST};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign rd_valid = st.rd_valid;
  assign rd_data  = st.rd_data;
  assign cpl_id   = st.cpl_id;

  // ****************************************
  // Assertions
  // ****************************************

  // The flops still sit in reset at the edge that releases it, so antecedents other than
  // those of p_dev_hold and p_b64_zero carry arst_n; otherwise that edge would start checks against ignored inputs
  property p_func_fixed;
    @(posedge clk) disable iff (!arst_n) st.func == BISR_FUNC_RST;
  endproperty
  a_func_fixed: assert property (p_func_fixed)
    else $error("Function number left its reset value");

  property p_dev_hold;
    @(posedge clk) disable iff (!arst_n) !hit |=> $stable(st.dev);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("Device number changed without a config write hit");

  property p_dev_load;
    @(posedge clk) disable iff (!arst_n)
      arst_n && hit |=> st.dev == $past(ap_ad[BISR_AD_DEV_MSB:BISR_AD_DEV_LSB]);
  endproperty
  a_dev_load: assert property (p_dev_load)
    else $error("Device number not loaded from AD[15:11]");

  property p_hit_decode;
    @(posedge clk) disable iff (!arst_n)
      arst_n && ap_valid && ap_idsel && (ap_cmd == BISR_CMD_CFG_WR) && (ap_ad[1:0] == BISR_TYPE0)
        && (ap_ad[BISR_AD_FUNC_MSB:BISR_AD_FUNC_LSB] == st.func)
        |=> st.dev == $past(ap_ad[BISR_AD_DEV_MSB:BISR_AD_DEV_LSB]);
  endproperty
  a_hit_decode: assert property (p_hit_decode)
    else $error("Qualifying config write did not load the device number");

  property p_bus_mirror;
    @(posedge clk) disable iff (!arst_n) arst_n |=> st.bus == $past(pri_bus_num);
  endproperty
  a_bus_mirror: assert property (p_bus_mirror)
    else $error("Bus number does not mirror the primary bus number");

  property p_cpl_id;
    @(posedge clk) disable iff (!arst_n)
      arst_n |=> cpl_id == {$past(st.bus), $past(st.dev), $past(st.func)};
  endproperty
  a_cpl_id: assert property (p_cpl_id)
    else $error("Completer ID does not match bus, device and function");

  property p_cpl_conv;
    @(posedge clk) disable iff (!arst_n)
      arst_n && hit |=> ##1 cpl_id[BISR_DEV_MSB:BISR_DEV_LSB] == $past(ap_ad[BISR_AD_DEV_MSB:BISR_AD_DEV_LSB], 2);
  endproperty
  a_cpl_conv: assert property (p_cpl_conv)
    else $error("Identity output lags a captured device number");

  property p_b64_zero;
    @(posedge clk) disable iff (!arst_n) rd_valid |-> rd_data[31:16] == 16'h0000;
  endproperty
  a_b64_zero: assert property (p_b64_zero)
    else $error("Bit 16 or upper bits read nonzero");

  property p_read_image;
    @(posedge clk) disable iff (!arst_n)
      arst_n && rd_req && (rd_offset == BISR_OFS_IDENT) |=>
        rd_valid && rd_data[15:0] == {$past(st.bus), $past(st.dev), $past(st.func)};
  endproperty
  a_read_image: assert property (p_read_image)
    else $error("Register read does not show the stored fields");

  // Every accepted read answers exactly one edge later, never early or twice
  property p_rd_strobe;
    @(posedge clk) disable iff (!arst_n) arst_n |=> rd_valid == $past(rd_req);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("Read answer strobe does not follow the request by one cycle");

  // The capability bit of a register read stays clear whatever was written
  property p_b64_image;
    @(posedge clk) disable iff (!arst_n)
      arst_n && rd_req && (rd_offset == BISR_OFS_IDENT) |=> rd_data[BISR_B64_BIT] == BISR_B64_VAL;
  endproperty
  a_b64_image: assert property (p_b64_image)
    else $error("64-bit capability bit read as set");

  // A write hit touches only the device number; no write data reaches func or bus
  property p_ro_hold;
    @(posedge clk) disable iff (!arst_n)
      arst_n && hit |=> st.func == $past(st.func) && st.bus == $past(pri_bus_num);
  endproperty
  a_ro_hold: assert property (p_ro_hold)
    else $error("Read-only field changed on a config write");

  // The function part of the identity never moves, in any bus mode
  property p_cpl_func;
    @(posedge clk) disable iff (!arst_n) cpl_id[BISR_FUNC_MSB:BISR_FUNC_LSB] == BISR_FUNC_RST;
  endproperty
  a_cpl_func: assert property (p_cpl_func)
    else $error("Completer ID function part moved");

endmodule

`default_nettype wire

// ---- sim/bisr_cfg_req.sv ----
// Configuration requester model that presents address phases
`timescale 1ns/1ps
`default_nettype none
module bisr_cfg_req
  import bisr_pkg::*;
(
  input  wire logic        clk,       // Bus clock
  output logic             ap_valid,  // Address phase strobe
  output logic [3:0]       ap_cmd,    // Bus command
  output logic             ap_idsel,  // IDSEL
  output logic [31:0]      ap_ad      // AD lines
);
  // Quiet bus at time zero
  initial begin
    ap_valid = 1'b0;
    ap_cmd   = 4'h0;
    ap_idsel = 1'b0;
    ap_ad    = 32'h0000_0000;
  end
  // One phase across one sampling edge; released lines then flip, so stale AD never looks valid
  task automatic phase(input logic [3:0] cmd, input logic sel, input logic [31:0] ad);
    @(posedge clk);
    ap_valid <= 1'b1;
    ap_cmd   <= cmd;
    ap_idsel <= sel;
    ap_ad    <= ad;
    @(posedge clk);
    ap_valid <= 1'b0;
    ap_idsel <= 1'b0;
    ap_cmd   <= ~cmd;
    ap_ad    <= ~ad;
  endtask
endmodule
`default_nettype wire

// ---- sim/bridge_identity_status_reg_tb.sv ----
// Self-checking bench for the bridge identity status register
`timescale 1ns/1ps
`default_nettype none
module bridge_identity_status_reg_tb;
  import bisr_pkg::*;
  // ****************************************
  // Signals and table
  // ****************************************
  logic        clk, arst_n, ap_valid, ap_idsel, rd_req, rd_valid;
  logic [3:0]  ap_cmd;
  logic [31:0] ap_ad, rd_data;
  logic [7:0]  pri_bus_num, rd_offset;
  logic [15:0] cpl_id;
  int          fail_count = 0;
  int          tests_run  = 0;
  typedef struct {logic [3:0] cmd; logic sel; logic [31:0] ad; logic [4:0] dev;} bisr_row_t;
  // Hit, then a miss on each of command, IDSEL, type and function, then a direct write to this register, then a hit loading device 0
  bisr_row_t rows [7] = '{'{4'hB, 1'b1, 32'h0000_5000, 5'h0A}, '{4'hA, 1'b1, 32'h0000_6000, 5'h0A},
    '{4'hB, 1'b0, 32'h0000_6000, 5'h0A}, '{4'hB, 1'b1, 32'h0000_6001, 5'h0A},
    '{4'hB, 1'b1, 32'h0000_6100, 5'h0A}, '{4'hB, 1'b1, 32'h0000_F884, 5'h1F},
    '{4'hB, 1'b1, 32'h0000_0000, 5'h00}};
  bisr_cfg_req req_u (.clk(clk), .ap_valid(ap_valid), .ap_cmd(ap_cmd), .ap_idsel(ap_idsel), .ap_ad(ap_ad));
  bisr_ident_status dut_u (.clk(clk), .arst_n(arst_n), .ap_valid(ap_valid), .ap_cmd(ap_cmd),
    .ap_idsel(ap_idsel), .ap_ad(ap_ad), .pri_bus_num(pri_bus_num), .rd_req(rd_req),
    .rd_offset(rd_offset), .rd_valid(rd_valid), .rd_data(rd_data), .cpl_id(cpl_id));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] word(input logic [7:0] bus, input logic [4:0] dev);
    return {15'h0000, 1'b0, bus, dev, 3'h0};
  endfunction
  // One read; answer looked at in its single valid cycle
  task automatic read_chk(input logic [7:0] ofs, input logic [31:0] exp);
    @(posedge clk);
    rd_req    <= 1'b1;
    rd_offset <= ofs;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    check("rd_valid", {31'h0, rd_valid}, 32'h1);
    check("rd_data", rd_data, exp);
  endtask
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    arst_n      = 1'b0;
    rd_req      = 1'b0;
    rd_offset   = 8'h00;
    pri_bus_num = 8'h5A;
    repeat (12) @(posedge clk);
    #1;
    check("cpl_id", {16'h0, cpl_id}, 32'h0000_FFF8);
    check("rd_data", rd_data, 32'h0000_0000);
    @(posedge clk);
    arst_n <= 1'b1;
    read_chk(BISR_OFS_IDENT, word(8'h5A, 5'h1F));
    foreach (rows[i]) begin
      req_u.phase(rows[i].cmd, rows[i].sel, rows[i].ad);
      read_chk(BISR_OFS_IDENT, word(8'h5A, rows[i].dev));
      check("cpl_id", {16'h0, cpl_id}, {16'h0, 8'h5A, rows[i].dev, 3'h0});
    end
    read_chk(8'h80, BISR_UNMAPPED_VAL);
    @(posedge clk);
    pri_bus_num <= 8'h3C;
    read_chk(BISR_OFS_IDENT, word(8'h3C, 5'h00));
    // Reset in mid-run brings the numbers back
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    check("cpl_id", {16'h0, cpl_id}, 32'h0000_FFF8);
    check("rd_valid", {31'h0, rd_valid}, 32'h0);
    check("rd_data", rd_data, 32'h0000_0000);
    // Release again; the device number is back at its reset value, bus stays live
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    read_chk(BISR_OFS_IDENT, word(8'h3C, 5'h1F));
    check("cpl_id", {16'h0, cpl_id}, {16'h0, 8'h3C, 5'h1F, 3'h0});
    test_done;
  end
  // Watchdog well past the expected run length
  initial begin
    #(25 * 4000);
    fail_count++;
    test_done;
  end
endmodule
`default_nettype wire
